/* rtl/adc_input_config_regs.sv */
`timescale 1ns/1ps
// What this block does
// - Word with top code 10001 writes the pseudo-differential select register.
// - Bits 10..3 pick pseudo-differential per pair, pair 0/1 at bit 10; reset zero.
// - Bit 2 refers inputs 0..14 to input 15 when set; reset zero.
// - Word with top code 10010 writes the bipolar select register.
// - Bits 10..3 pick bipolar per pair, pair 0/1 at bit 10; reset zero.
// - Bipolar bit alone gives differential pair with two's-complement coding.
// - Pseudo-differential bit gives pair conversion with straight binary coding.
// - Pseudo-differential bit wins over bipolar bit: straight binary unipolar.
// - Common-reference flag overrides pair bits; convert against input 15, binary.
module adc_input_config_regs
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // Configuration word from the serial front end
  input  wire logic [WORD_W-1:0]     cfg_word,
  input  wire logic                  cfg_word_valid,
  // Channel being converted
  input  wire logic [CHAN_W-1:0]     channel_index,
  // Register contents
  output logic      [PAIR_COUNT-1:0] pair_pseudo_diff_bit,
  output logic      [PAIR_COUNT-1:0] pair_bipolar_bit,
  output logic                       common_reference_flag,
  // Conversion setup for the selected channel
  output conv_mode_type              conv_mode,
  output logic                       twos_complement
);

  logic [WORD_W-1:0]     pseudo_diff_q;
  logic [WORD_W-1:0]     pseudo_diff_d;
  logic [WORD_W-1:0]     bipolar_q;
  logic [WORD_W-1:0]     bipolar_d;
  conv_mode_type         conv_mode_q;
  logic                  twos_complement_q;

  cfg_word_if cfg ();

  // Select decode
  wire [4:0] select_code      = cfg_word[SEL_MSB:SEL_LSB];
  wire       pseudo_diff_hit  = cfg_word_valid
                                && (select_code == PSEUDO_DIFF_REG_SELECT_CODE);
  wire       bipolar_hit      = cfg_word_valid
                                && (select_code == BIPOLAR_REG_SELECT_CODE);

  // Only pair and flag fields are stored; unused bits stay zero
  wire [WORD_W-1:0] pseudo_diff_mask = 16'h07fc;
  wire [WORD_W-1:0] bipolar_mask     = 16'h07f8;

  assign pseudo_diff_d = pseudo_diff_hit ? (cfg_word & pseudo_diff_mask)
                                         : pseudo_diff_q;
  assign bipolar_d     = bipolar_hit ? (cfg_word & bipolar_mask)
                                     : bipolar_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pseudo_diff_q <= PSEUDO_DIFF_RESET;
      bipolar_q     <= BIPOLAR_RESET;
    end else begin
      pseudo_diff_q <= pseudo_diff_d;
      bipolar_q     <= bipolar_d;
    end
  end

  // Pair p sits at bit 10-p, so the field is bit-reversed into pair order
  genvar p;
  generate
    for (p = 0; p < PAIR_COUNT; p++) begin : g_pair
      assign cfg.pair_pseudo_diff_bit[p] = pseudo_diff_q[PAIR_MSB-p];
      assign cfg.pair_bipolar_bit[p]     = bipolar_q[PAIR_MSB-p];

      // Clocked here since the default clocking is declared further down
      pair_pseudo_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        pseudo_diff_hit |=> (pair_pseudo_diff_bit[p] == $past(cfg_word[PAIR_MSB-p]))
      ) else $error("pseudo-diff pair bit misplaced");

      pair_bipolar_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        bipolar_hit |=> (pair_bipolar_bit[p] == $past(cfg_word[PAIR_MSB-p]))
      ) else $error("bipolar pair bit misplaced");
    end
  endgenerate

  assign cfg.common_reference_flag = pseudo_diff_q[COM_REF_BIT];
  assign cfg.channel_index         = channel_index;

  input_mode_decode input_mode_decode_inst (
    .cfg (cfg)
  );

  // Registered so the converter sees a glitch-free setup
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_mode_q       <= mode_single_ended;
      twos_complement_q <= 1'b0;
    end else begin
      conv_mode_q       <= cfg.conv_mode;
      twos_complement_q <= cfg.twos_complement;
    end
  end

  assign pair_pseudo_diff_bit  = cfg.pair_pseudo_diff_bit;
  assign pair_bipolar_bit      = cfg.pair_bipolar_bit;
  assign common_reference_flag = pseudo_diff_q[COM_REF_BIT];
  assign conv_mode             = conv_mode_q;
  assign twos_complement       = twos_complement_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  wire [2:0] pair_sel    = channel_index[CHAN_W-1:1];
  wire       pair_pseudo = cfg.pair_pseudo_diff_bit[pair_sel];
  wire       pair_bip    = cfg.pair_bipolar_bit[pair_sel];

  // Raw field compare; the pair reversal is checked per pair above
  pseudo_write_a: assert property (
    pseudo_diff_hit
    |=> (pseudo_diff_q[PAIR_MSB:PAIR_LSB] == $past(cfg_word[PAIR_MSB:PAIR_LSB]))
  ) else $error("pseudo-diff write not stored");

  pseudo_order_a: assert property (
    pseudo_diff_hit && cfg_word[PAIR_MSB] |=> pair_pseudo_diff_bit[0]
  ) else $error("pair 0/1 not at top pair bit");

  pseudo_low_order_a: assert property (
    pseudo_diff_hit && cfg_word[PAIR_LSB] |=> pair_pseudo_diff_bit[PAIR_COUNT-1]
  ) else $error("pair 14/15 not at bottom pair bit");

  com_flag_a: assert property (
    pseudo_diff_hit |=> (common_reference_flag == $past(cfg_word[COM_REF_BIT]))
  ) else $error("common reference flag not stored");

  bipolar_write_a: assert property (
    bipolar_hit
    |=> (bipolar_q[PAIR_MSB:PAIR_LSB] == $past(cfg_word[PAIR_MSB:PAIR_LSB]))
  ) else $error("bipolar write not stored");

  bipolar_order_a: assert property (
    bipolar_hit && cfg_word[PAIR_LSB] |=> pair_bipolar_bit[PAIR_COUNT-1]
  ) else $error("pair 14/15 not at bit 3");

  bipolar_high_order_a: assert property (
    bipolar_hit && cfg_word[PAIR_MSB] |=> pair_bipolar_bit[0]
  ) else $error("pair 0/1 not at bit 10");

  twos_coding_a: assert property (
    pair_bip && !pair_pseudo && !common_reference_flag
    |=> (conv_mode == mode_pair_bipolar) && twos_complement
  ) else $error("bipolar pair not two's complement");

  // Checks both ways: settings give the expected mode and each mode traces to its settings; writes touch only their register
  twos_source_a: assert property (
    twos_complement
    |-> $past(pair_bip && !pair_pseudo && !common_reference_flag)
  ) else $error("two's complement without bipolar pair");

  bipolar_source_a: assert property (
    (conv_mode == mode_pair_bipolar)
    |-> $past(pair_bip && !pair_pseudo && !common_reference_flag)
  ) else $error("bipolar mode without bipolar pair");

  pseudo_mode_a: assert property (
    pair_pseudo && !common_reference_flag
    |=> (conv_mode == mode_pair_unipolar) && !twos_complement
  ) else $error("pseudo-diff pair not straight binary");

  unipolar_source_a: assert property (
    (conv_mode == mode_pair_unipolar)
    |-> $past(pair_pseudo && !common_reference_flag)
  ) else $error("pair unipolar mode without pseudo-diff bit");

  pseudo_wins_a: assert property (
    pair_pseudo && pair_bip && !common_reference_flag |=> !twos_complement
  ) else $error("bipolar setting beat pseudo-diff");

  both_set_mode_a: assert property (
    pair_pseudo && pair_bip && !common_reference_flag
    |=> (conv_mode == mode_pair_unipolar)
  ) else $error("both pair bits set but not pair unipolar");

  com_override_a: assert property (
    common_reference_flag |=> (conv_mode == mode_common_ref) && !twos_complement
  ) else $error("common reference did not override");

  com_over_bip_a: assert property (
    common_reference_flag && pair_bip |=> (conv_mode == mode_common_ref)
  ) else $error("bipolar bit beat common reference");

  com_over_pseudo_a: assert property (
    common_reference_flag && pair_pseudo |=> (conv_mode == mode_common_ref)
  ) else $error("pseudo-diff bit beat common reference");

  common_source_a: assert property (
    (conv_mode == mode_common_ref) |-> $past(common_reference_flag)
  ) else $error("common reference mode without flag");

  plain_input_a: assert property (
    !pair_pseudo && !pair_bip && !common_reference_flag
    |=> (conv_mode == mode_single_ended) && !twos_complement
  ) else $error("clear pair not single ended");

  single_source_a: assert property (
    (conv_mode == mode_single_ended)
    |-> $past(!pair_pseudo && !pair_bip && !common_reference_flag)
  ) else $error("single ended mode with a pair bit set");

  other_code_a: assert property (
    !pseudo_diff_hit && !bipolar_hit
    |=> $stable(pair_pseudo_diff_bit) && $stable(pair_bipolar_bit)
        && $stable(common_reference_flag)
  ) else $error("register changed without its code");

  bip_kept_a: assert property (
    pseudo_diff_hit |=> $stable(bipolar_q)
  ) else $error("pseudo-diff write touched bipolar register");

  pseudo_kept_a: assert property (
    bipolar_hit |=> $stable(pseudo_diff_q)
  ) else $error("bipolar write touched pseudo-diff register");

  // Unused bits must never hold a code or stray low bits
  pseudo_clean_a: assert property (
    (pseudo_diff_q[SEL_MSB:SEL_LSB] == '0) && (pseudo_diff_q[COM_REF_BIT-1:0] == '0)
  ) else $error("pseudo-diff register holds unused bits");

  bipolar_clean_a: assert property (
    (bipolar_q[SEL_MSB:SEL_LSB] == '0) && (bipolar_q[PAIR_LSB-1:0] == '0)
  ) else $error("bipolar register holds unused bits");

  same_pair_a: assert property (
    $stable(pseudo_diff_q) && $stable(bipolar_q)
    && ($past(channel_index[CHAN_W-1:1]) == channel_index[CHAN_W-1:1])
    |=> $stable(conv_mode)
  ) else $error("channels of one pair differ in mode");

endmodule // adc_input_config_regs

/* rtl/adc_cfg_pkg.sv */
package adc_cfg_pkg;

  localparam int unsigned WORD_W       = 16;
  localparam int unsigned PAIR_COUNT   = 8;
  localparam int unsigned CHAN_W       = 4;

  // Word layout
  localparam int unsigned SEL_MSB      = 15;
  localparam int unsigned SEL_LSB      = 11;
  localparam int unsigned PAIR_MSB     = 10;
  localparam int unsigned PAIR_LSB     = 3;
  localparam int unsigned COM_REF_BIT  = 2;

  localparam logic [4:0] PSEUDO_DIFF_REG_SELECT_CODE = 5'h11;
  localparam logic [4:0] BIPOLAR_REG_SELECT_CODE     = 5'h12;

  localparam logic [WORD_W-1:0] PSEUDO_DIFF_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] BIPOLAR_RESET     = 16'h0000;

  // Cycles from channel_index to registered mode outputs
  localparam int unsigned MODE_LATENCY = 1;

  typedef enum logic [1:0] {
    mode_single_ended,
    mode_pair_unipolar,
    mode_pair_bipolar,
    mode_common_ref
  } conv_mode_type;

endpackage

/* rtl/cfg_word_if.sv */
`timescale 1ns/1ps
interface cfg_word_if;
  import adc_cfg_pkg::*;

  logic [PAIR_COUNT-1:0] pair_pseudo_diff_bit;
  logic [PAIR_COUNT-1:0] pair_bipolar_bit;
  logic                  common_reference_flag;
  logic [CHAN_W-1:0]     channel_index;
  conv_mode_type         conv_mode;
  logic                  twos_complement;

  modport regs (
    output pair_pseudo_diff_bit,
    output pair_bipolar_bit,
    output common_reference_flag,
    output channel_index,
    input  conv_mode,
    input  twos_complement
  );

  modport decode (
    input  pair_pseudo_diff_bit,
    input  pair_bipolar_bit,
    input  common_reference_flag,
    input  channel_index,
    output conv_mode,
    output twos_complement
  );
endinterface

/* rtl/input_mode_decode.sv */
`timescale 1ns/1ps
module input_mode_decode
  import adc_cfg_pkg::*;
(
  cfg_word_if.decode cfg
);

  // Both channels of a pair share one pair bit
  wire [2:0] pair_index  = cfg.channel_index[CHAN_W-1:1];
  wire       pseudo_bit  = cfg.pair_pseudo_diff_bit[pair_index];
  wire       bipolar_bit = cfg.pair_bipolar_bit[pair_index];

  // Common reference overrides everything, then pseudo-differential
  assign cfg.conv_mode =
    cfg.common_reference_flag ? mode_common_ref :
    pseudo_bit                ? mode_pair_unipolar :
    bipolar_bit               ? mode_pair_bipolar :
                                mode_single_ended;

  assign cfg.twos_complement = (cfg.conv_mode == mode_pair_bipolar);

endmodule // input_mode_decode

/* test/cfg_host_model.sv */
`timescale 1ns/1ps
module cfg_host_model
  import adc_cfg_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Word to the device
  output logic      [WORD_W-1:0] cfg_word,
  output logic                   cfg_word_valid
);
  initial begin
    cfg_word       = 16'h0000;
    cfg_word_valid = 1'b0;
  end
  // Idle word inverted so a stale word is never trusted
  task automatic send(input logic [WORD_W-1:0] w);
    @(negedge ref_clk);
    cfg_word       = w;
    cfg_word_valid = 1'b1;
    @(negedge ref_clk);
    cfg_word_valid = 1'b0;
    cfg_word       = ~w;
  endtask
endmodule // cfg_host_model

/* test/test_adc_input_config_regs.sv */
`timescale 1ns/1ps
module test_adc_input_config_regs;
  import adc_cfg_pkg::*;
  logic                  ref_clk;
  logic                  reset_n;
  logic [WORD_W-1:0]     cfg_word;
  logic                  cfg_word_valid;
  logic [CHAN_W-1:0]     channel_index;
  logic [PAIR_COUNT-1:0] pseudo_bits;
  logic [PAIR_COUNT-1:0] bipolar_bits;
  logic                  flag;
  logic                  twos;
  conv_mode_type         mode;
  int                    fail_count = 0;
  int                    num_checks = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  cfg_host_model cfg_host_model_inst (.ref_clk(ref_clk), .cfg_word(cfg_word),
    .cfg_word_valid(cfg_word_valid));
  adc_input_config_regs adc_input_config_regs_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid), .channel_index(channel_index),
    .pair_pseudo_diff_bit(pseudo_bits), .pair_bipolar_bit(bipolar_bits),
    .common_reference_flag(flag), .conv_mode(mode), .twos_complement(twos));

  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_mode(input logic [3:0] ch, input conv_mode_type exp);
    num_checks++;
    if (mode !== exp || twos !== (exp == mode_pair_bipolar)) begin
      fail_count++;
      $display("[FAIL] %0t channel %0d mode %0d exp %0d", $time, ch, mode, exp);
    end
  endtask

  // Low bits set on purpose; they must be ignored
  function automatic logic [15:0] word_of(input logic [4:0] c, input logic [7:0] p,
                                          input logic f);
    logic [15:0] w;
    w = {c, 8'h00, f, 2'b11};
    for (int i = 0; i < 8; i++) w[10-i] = p[i];
    return w;
  endfunction

  task automatic test_reset();
    chk_bits(pseudo_bits, 8'h00, "pseudo reset");
    chk_bits(bipolar_bits, 8'h00, "bipolar reset");
    chk_bits({7'h00, flag}, 8'h00, "flag reset");
    chk_mode(4'h0, mode_single_ended);
    $display("test_reset done");
  endtask

  task automatic test_writes();
    cfg_host_model_inst.send(word_of(PSEUDO_DIFF_REG_SELECT_CODE, 8'h06, 1'b0));
    cfg_host_model_inst.send(word_of(BIPOLAR_REG_SELECT_CODE, 8'h05, 1'b1));
    cfg_host_model_inst.send(word_of(5'h13, 8'hff, 1'b1));
    cfg_host_model_inst.send(word_of(5'h01, 8'hff, 1'b1));
    @(negedge ref_clk);
    chk_bits(pseudo_bits, 8'h06, "pseudo value");
    chk_bits(bipolar_bits, 8'h05, "bipolar value");
    chk_bits({7'h00, flag}, 8'h00, "flag value");
    $display("test_writes done");
  endtask

  // Pair 0 bipolar only, pair 1 pseudo only, pair 2 both, pair 3 neither
  task automatic test_modes(input logic f);
    conv_mode_type e;
    logic [7:0]    ep;
    logic [7:0]    eb;
    ep = 8'h06;
    eb = 8'h05;
    for (int ch = 0; ch < 16; ch++) begin
      channel_index = ch[3:0];
      @(negedge ref_clk);
      @(negedge ref_clk);
      e = f ? mode_common_ref : ep[ch/2] ? mode_pair_unipolar :
          eb[ch/2] ? mode_pair_bipolar : mode_single_ended;
      chk_mode(ch[3:0], e);
    end
    $display("test_modes done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset_n       = 1'b0;
    channel_index = 4'h0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    test_reset();
    test_writes();
    test_modes(1'b0);
    cfg_host_model_inst.send(word_of(PSEUDO_DIFF_REG_SELECT_CODE, 8'h06, 1'b1));
    @(negedge ref_clk);
    chk_bits({7'h00, flag}, 8'h01, "flag set");
    chk_bits(pseudo_bits, 8'h06, "pseudo with flag");
    test_modes(1'b1);
    tally_and_finish();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end
endmodule // test_adc_input_config_regs
